//--- stp_ctrl_regs.v
// control register bank of the stepper driver with its serial slave port
// Behaviour
// - all control bits zero after reset, read/write
// - reg 01h: step mode 7:5, current 4:0
// - reg 02h: invert, edge, pwm freq, jitter, slope
// - reg 03h: enable, sleep, gain, transparency
// - current code selects peak current table
// - transparency bit zero means output transparent
// - gain bit selects 0.5 or 0.25
// - pwm at 22.8 kHz or 45.6 kHz
// - jitter bit enables jittered pwm period
// - sleep bit selects sleep or active mode
// - enable bit gates bridge drivers
// - direction pin xor invert bit sets rotation
// - polarity bit picks rising or falling step edge
// - slope code picks 150/100/50/25 V/us
// - step mode code decode, seven reserved
// - write commits only 16-bit frame at deselect
`timescale 1ns/100ps
`default_nettype none
`include "stp_map.vh"

module stp_ctrl_regs #(
  parameter PWM_CYCLES = `STP_PWM_CYCLES,
  parameter PWM_W = 13
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // serial port
  input wire chipSelectLow_n,
  input wire serialClk,
  input wire serialIn,
  output reg serialOut,
  output reg serialOutOe,
  // motion pins
  input wire dirPin,
  input wire stepAdvanceInput,
  // step and current
  output reg [2:0] stepModeSelect,
  output reg stepModeReserved,
  output reg [5:0] microstepsPerFull,
  output reg compensatedHalf,
  output reg [4:0] currentAmplitudeCode,
  output wire [9:0] peakCoilCurrent,
  // motion
  output reg rotateCcw,
  output reg stepPulse,
  // pwm and slope
  output reg pwmDouble,
  output reg pwmJitter,
  output reg pwmTick,
  output reg [1:0] slopeSelector,
  output reg [7:0] slopeVoltsPerUs,
  // enables and load-angle output
  output reg bridgeEnable,
  output reg sleepMode,
  output reg slaGainQuarter,
  output reg slaTransparent
);

  // ==========================================================
  // registers
  reg [7:0] stepCurCtrl;
  reg [7:0] dirPwmCtrl;
  reg [7:0] enSlpSlaCtrl;

  // ==========================================================
  // serial receive and transmit
  reg sclkPrev;
  reg csPrev_n;
  reg [15:0] shiftIn;
  reg [4:0] bitCnt;
  reg cmdPhase;
  reg [4:0] lastAddr;
  reg [7:0] outShift;

  wire selected = !chipSelectLow_n;
  wire sclkRise = serialClk && !sclkPrev;
  wire sclkFall = !serialClk && sclkPrev;
  wire deselectEdge = chipSelectLow_n && !csPrev_n;
  wire byteDone = (bitCnt[2:0] == 3'h0) && (bitCnt != 5'h00);

  function [7:0] readMux;
    input [4:0] addr;
    begin
      case (addr)
        `STP_ADDR_STEP_CUR: readMux = stepCurCtrl;
        `STP_ADDR_DIR_PWM: readMux = dirPwmCtrl;
        `STP_ADDR_EN_SLP_SLA: readMux = enSlpSlaCtrl;
        default: readMux = 8'h00;
      endcase
    end
  endfunction

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev <= 1'b0;
      csPrev_n <= 1'b1;
      shiftIn <= 16'h0000;
      bitCnt <= 5'h00;
      cmdPhase <= 1'b1;
      lastAddr <= 5'h00;
      outShift <= 8'hFF;
      serialOut <= 1'b1;
      serialOutOe <= 1'b0;
    end else begin
      sclkPrev <= serialClk;
      csPrev_n <= chipSelectLow_n;
      if (!selected) begin
        bitCnt <= 5'h00;
        cmdPhase <= 1'b1;
      end else if (sclkRise) begin
        shiftIn <= {shiftIn[14:0], serialIn};
        // saturate so any longer frame never looks like 16 bits
        if (bitCnt != 5'h1F) begin
          bitCnt <= bitCnt + 5'h01;
        end
      end else if (sclkFall) begin
        if (byteDone) begin
          if (cmdPhase) begin
            lastAddr <= shiftIn[4:0];
            cmdPhase <= !shiftIn[`STP_CMD_WRITE_BIT];
            outShift <= readMux(shiftIn[4:0]);
          end else begin
            cmdPhase <= 1'b1;
            outShift <= readMux(lastAddr);
          end
        end else begin
          outShift <= {outShift[6:0], 1'b1};
        end
      end
      // open drain: only ever pull low
      serialOut <= 1'b0;
      serialOutOe <= selected && !outShift[7];
    end
  end

  // ==========================================================
  // register writes
  wire frameWrite = deselectEdge && (bitCnt == `STP_FRAME_BITS)
                    && shiftIn[8 + `STP_CMD_WRITE_BIT];
  wire [4:0] frameAddr = shiftIn[12:8];

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stepCurCtrl <= `STP_RST_STEP_CUR;
      dirPwmCtrl <= `STP_RST_DIR_PWM;
      enSlpSlaCtrl <= `STP_RST_EN_SLP_SLA;
    end else if (frameWrite) begin
      case (frameAddr)
        `STP_ADDR_STEP_CUR: stepCurCtrl <= shiftIn[7:0];
        `STP_ADDR_DIR_PWM: dirPwmCtrl <= shiftIn[7:0] & `STP_DIR_PWM_MASK;
        `STP_ADDR_EN_SLP_SLA: enSlpSlaCtrl <= shiftIn[7:0] & `STP_EN_SLP_SLA_MASK;
        default: stepCurCtrl <= stepCurCtrl;
      endcase
    end
  end

  // ==========================================================
  // field decode
  wire [2:0] smField = stepCurCtrl[`STP_STEP_MODE_HI:`STP_STEP_MODE_LO];
  wire [1:0] slField = dirPwmCtrl[`STP_SLOPE_HI:`STP_SLOPE_LO];
  wire sleepBit = enSlpSlaCtrl[`STP_SLEEP_BIT];

  stp_cur_rom u_cur_rom (
    .clk(clk),
    .arst_n(arst_n),
    .code(stepCurCtrl[`STP_CUR_HI:`STP_CUR_LO]),
    .milliAmps(peakCoilCurrent)
  );

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stepModeSelect <= 3'h0;
      stepModeReserved <= 1'b0;
      microstepsPerFull <= 6'h20;
      compensatedHalf <= 1'b0;
      currentAmplitudeCode <= 5'h00;
      slopeSelector <= 2'h0;
      slopeVoltsPerUs <= `STP_SLOPE_0;
      pwmDouble <= 1'b0;
      pwmJitter <= 1'b0;
      bridgeEnable <= 1'b0;
      sleepMode <= 1'b0;
      slaGainQuarter <= 1'b0;
      slaTransparent <= 1'b1;
      rotateCcw <= 1'b0;
    end else begin
      stepModeSelect <= smField;
      currentAmplitudeCode <= stepCurCtrl[`STP_CUR_HI:`STP_CUR_LO];
      stepModeReserved <= (smField == `STP_SM_RSVD);
      compensatedHalf <= (smField == `STP_SM_HALF_CMP);
      case (smField)
        `STP_SM_32: microstepsPerFull <= 6'h20;
        `STP_SM_16: microstepsPerFull <= 6'h10;
        `STP_SM_8: microstepsPerFull <= 6'h08;
        `STP_SM_4: microstepsPerFull <= 6'h04;
        `STP_SM_HALF_UNC: microstepsPerFull <= 6'h02;
        `STP_SM_HALF_CMP: microstepsPerFull <= 6'h02;
        `STP_SM_FULL: microstepsPerFull <= 6'h01;
        default: microstepsPerFull <= 6'h00;
      endcase
      slopeSelector <= slField;
      case (slField)
        2'h0: slopeVoltsPerUs <= `STP_SLOPE_0;
        2'h1: slopeVoltsPerUs <= `STP_SLOPE_1;
        2'h2: slopeVoltsPerUs <= `STP_SLOPE_2;
        default: slopeVoltsPerUs <= `STP_SLOPE_3;
      endcase
      pwmDouble <= dirPwmCtrl[`STP_PWM_FREQ_BIT];
      pwmJitter <= dirPwmCtrl[`STP_PWM_JIT_BIT];
      bridgeEnable <= enSlpSlaCtrl[`STP_MOT_EN_BIT];
      sleepMode <= sleepBit;
      slaGainQuarter <= enSlpSlaCtrl[`STP_SLA_GAIN_BIT];
      slaTransparent <= !enSlpSlaCtrl[`STP_SLA_TRANSP_BIT];
      rotateCcw <= dirPin ^ dirPwmCtrl[`STP_DIR_INV_BIT];
    end
  end

  // ==========================================================
  // step edge detect
  reg stepPrev;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stepPrev <= 1'b0;
      stepPulse <= 1'b0;
    end else begin
      stepPrev <= stepAdvanceInput;
      // step input is forbidden while asleep, so edges are dropped
      if (dirPwmCtrl[`STP_EDGE_POL_BIT]) begin
        stepPulse <= !sleepBit && stepPrev && !stepAdvanceInput;
      end else begin
        stepPulse <= !sleepBit && !stepPrev && stepAdvanceInput;
      end
    end
  end

  // ==========================================================
  // pwm period divider
  localparam [PWM_W-1:0] PWM_FULL = PWM_CYCLES[PWM_W-1:0];
  localparam [PWM_W-1:0] PWM_HALF = PWM_CYCLES[PWM_W:1];

  reg [PWM_W-1:0] pwmCnt;
  reg [7:0] lfsr;
  wire [PWM_W-1:0] pwmBase = dirPwmCtrl[`STP_PWM_FREQ_BIT] ? PWM_HALF : PWM_FULL;
  // jitter only lengthens the period by up to 15 cycles, mean shifts slightly
  wire [PWM_W-1:0] pwmJit = dirPwmCtrl[`STP_PWM_JIT_BIT] ?
                            {{(PWM_W-4){1'b0}}, lfsr[3:0]} : {PWM_W{1'b0}};
  wire [PWM_W-1:0] pwmLast = pwmBase + pwmJit - {{(PWM_W-1){1'b0}}, 1'b1};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwmCnt <= {PWM_W{1'b0}};
      lfsr <= 8'h01;
      pwmTick <= 1'b0;
    end else if (sleepBit) begin
      pwmCnt <= {PWM_W{1'b0}};
      pwmTick <= 1'b0;
    end else if (pwmCnt >= pwmLast) begin
      pwmCnt <= {PWM_W{1'b0}};
      pwmTick <= 1'b1;
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end else begin
      pwmCnt <= pwmCnt + {{(PWM_W-1){1'b0}}, 1'b1};
      pwmTick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- stp_map.vh
// register map, field positions, reset values and timing constants of the control bank
`ifndef STP_MAP_VH
`define STP_MAP_VH

// ==========================================================
// register addresses
`define STP_ADDR_W 5
`define STP_ADDR_STEP_CUR 5'h01
`define STP_ADDR_DIR_PWM 5'h02
`define STP_ADDR_EN_SLP_SLA 5'h03

// ==========================================================
// reset values
`define STP_RST_STEP_CUR 8'h00
`define STP_RST_DIR_PWM 8'h00
`define STP_RST_EN_SLP_SLA 8'h00

// ==========================================================
// step_and_current_control fields
`define STP_STEP_MODE_HI 7
`define STP_STEP_MODE_LO 5
`define STP_CUR_HI 4
`define STP_CUR_LO 0

// ==========================================================
// direction_and_pwm_control fields
`define STP_DIR_INV_BIT 7
`define STP_EDGE_POL_BIT 6
`define STP_PWM_FREQ_BIT 3
`define STP_PWM_JIT_BIT 2
`define STP_SLOPE_HI 1
`define STP_SLOPE_LO 0
`define STP_DIR_PWM_MASK 8'hCF

// ==========================================================
// enable_sleep_loadangle_control fields
`define STP_MOT_EN_BIT 7
`define STP_SLEEP_BIT 6
`define STP_SLA_GAIN_BIT 5
`define STP_SLA_TRANSP_BIT 4
`define STP_EN_SLP_SLA_MASK 8'hF0

// ==========================================================
// serial frame
`define STP_FRAME_BITS 5'h10
`define STP_CMD_WRITE_BIT 7

// ==========================================================
// step modes
`define STP_SM_32 3'h0
`define STP_SM_16 3'h1
`define STP_SM_8 3'h2
`define STP_SM_4 3'h3
`define STP_SM_HALF_UNC 3'h4
`define STP_SM_HALF_CMP 3'h5
`define STP_SM_FULL 3'h6
`define STP_SM_RSVD 3'h7

// ==========================================================
// slopes in V/us per selector code
`define STP_SLOPE_0 8'h96
`define STP_SLOPE_1 8'h64
`define STP_SLOPE_2 8'h32
`define STP_SLOPE_3 8'h19

// ==========================================================
// timing
`define STP_CLK_HZ 125000000
`define STP_PWM_HZ 22800
`define STP_PWM_CYCLES (`STP_CLK_HZ / `STP_PWM_HZ)

`endif

//--- stp_cur_rom.v
// peak coil current table, code to milliamps, registered read
`timescale 1ns/100ps
`default_nettype none

module stp_cur_rom (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // lookup
  input wire [4:0] code,
  output reg [9:0] milliAmps
);

  // ==========================================================
  // table
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      milliAmps <= 10'h00F;
    end else begin
      case (code)
        5'h00: milliAmps <= 10'h00F;
        5'h01: milliAmps <= 10'h01E;
        5'h02: milliAmps <= 10'h02D;
        5'h03: milliAmps <= 10'h032;
        5'h04: milliAmps <= 10'h037;
        5'h05: milliAmps <= 10'h03D;
        5'h06: milliAmps <= 10'h043;
        5'h07: milliAmps <= 10'h04A;
        5'h08: milliAmps <= 10'h052;
        5'h09: milliAmps <= 10'h05B;
        5'h0A: milliAmps <= 10'h064;
        5'h0B: milliAmps <= 10'h06E;
        5'h0C: milliAmps <= 10'h07A;
        5'h0D: milliAmps <= 10'h087;
        5'h0E: milliAmps <= 10'h095;
        5'h0F: milliAmps <= 10'h0A4;
        5'h10: milliAmps <= 10'h0B5;
        5'h11: milliAmps <= 10'h0C8;
        5'h12: milliAmps <= 10'h0DD;
        5'h13: milliAmps <= 10'h0F4;
        5'h14: milliAmps <= 10'h10D;
        5'h15: milliAmps <= 10'h129;
        5'h16: milliAmps <= 10'h148;
        5'h17: milliAmps <= 10'h16A;
        5'h18: milliAmps <= 10'h190;
        5'h19: milliAmps <= 10'h1B9;
        5'h1A: milliAmps <= 10'h1E7;
        5'h1B: milliAmps <= 10'h21A;
        5'h1C: milliAmps <= 10'h252;
        5'h1D: milliAmps <= 10'h290;
        5'h1E: milliAmps <= 10'h2D4;
        default: milliAmps <= 10'h320;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- stp_ctrl_regs_checker.sv
// assertion checker for the stepper control register bank
`timescale 1ns/100ps
`default_nettype none

module stp_ctrl_regs_checker (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serial and step pins, pwm tick and sleep mode
  input wire logic chipSelectLow_n,
  input wire logic serialOutOe,
  input wire logic stepAdvanceInput,
  input wire logic stepPulse,
  input wire logic pwmTick,
  input wire logic sleepMode,
  // decoded fields
  input wire logic [2:0] stepModeSelect,
  input wire logic stepModeReserved,
  input wire logic [5:0] microstepsPerFull,
  input wire logic compensatedHalf,
  input wire logic [4:0] currentAmplitudeCode,
  input wire logic [9:0] peakCoilCurrent,
  input wire logic [1:0] slopeSelector,
  input wire logic [7:0] slopeVoltsPerUs
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [2:0] m;
  assign m = stepModeSelect;

  property p_micro;
    $stable(m) |-> microstepsPerFull ==
      (m == 3'h7 ? 6'h00 : m == 3'h6 ? 6'h01 : m > 3'h3 ? 6'h02 : 6'h20 >> m);
  endproperty
  a_micro: assert property (p_micro) else $error("microsteps decode wrong");
  property p_rsvd;
    $stable(m) |-> stepModeReserved == (m == 3'h7);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved flag wrong");
  property p_comp;
    $stable(m) |-> compensatedHalf == (m == 3'h5);
  endproperty
  a_comp: assert property (p_comp) else $error("compensated flag wrong");
  property p_slope;
    $stable(slopeSelector) |-> slopeVoltsPerUs == (slopeSelector == 2'h0 ? 8'h96 :
      slopeSelector == 2'h1 ? 8'h64 : slopeSelector == 2'h2 ? 8'h32 : 8'h19);
  endproperty
  a_slope: assert property (p_slope) else $error("slope decode wrong");
  property p_cur_lo;
    (currentAmplitudeCode == 5'h00) [*3] |-> peakCoilCurrent == 10'h00F;
  endproperty
  a_cur_lo: assert property (p_cur_lo) else $error("lowest current wrong");
  property p_cur_hi;
    (currentAmplitudeCode == 5'h1F) [*3] |-> peakCoilCurrent == 10'h320;
  endproperty
  a_cur_hi: assert property (p_cur_hi) else $error("highest current wrong");
  property p_step;
    stepPulse |-> ($past(stepAdvanceInput) != $past(stepAdvanceInput, 2)) ##1 !stepPulse;
  endproperty
  a_step: assert property (p_step) else $error("step pulse without edge");
  property p_sleep_step;
    sleepMode [*3] |-> !stepPulse;
  endproperty
  a_sleep_step: assert property (p_sleep_step) else $error("step while asleep");
  property p_sleep_pwm;
    sleepMode [*3] |-> !pwmTick;
  endproperty
  a_sleep_pwm: assert property (p_sleep_pwm) else $error("pwm while asleep");
  property p_oe;
    chipSelectLow_n [*3] |-> !serialOutOe;
  endproperty
  a_oe: assert property (p_oe) else $error("data line driven unselected");

  c_step: cover property (stepPulse);
  c_tick: cover property (pwmTick ##[1:60] pwmTick);
  c_rsvd: cover property (stepModeReserved);
endmodule

bind stp_ctrl_regs stp_ctrl_regs_checker i_chk (.clk, .arst_n, .chipSelectLow_n,
  .serialOutOe, .stepAdvanceInput, .stepPulse, .pwmTick, .sleepMode, .stepModeSelect,
  .stepModeReserved, .microstepsPerFull, .compensatedHalf, .currentAmplitudeCode,
  .peakCoilCurrent, .slopeSelector, .slopeVoltsPerUs);

`default_nettype wire

//--- stp_spi_master.sv
// serial master model driving the control port in mode 0
`timescale 1ns/100ps
`default_nettype none

module stp_spi_master (
  // system clock
  input wire logic clk,
  // serial lines
  output logic chipSelectLow_n,
  output logic serialClk,
  output logic serialIn,
  input wire logic doLine
);
  // clk cycles per serial clock level, raise for a slow master
  int hp = 3;

  task automatic frame(input logic [16:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk) chipSelectLow_n <= 1'b0;
    repeat (hp) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      serialIn <= tx[i];
      repeat (hp) @(negedge clk);
      rx = {rx[14:0], doLine};
      serialClk <= 1'b1;
      repeat (hp) @(negedge clk);
      serialClk <= 1'b0;
    end
    repeat (hp) @(negedge clk);
    chipSelectLow_n <= 1'b1;
    serialIn <= ~serialIn;
    repeat (hp) @(negedge clk);
  endtask

  initial begin
    chipSelectLow_n = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
endmodule

`default_nettype wire

//--- stp_ctrl_regs_tb_top.sv
// self-checking testbench of the stepper control register bank
`timescale 1ns/100ps
`default_nettype none

module stp_ctrl_regs_tb_top;
  // ==========================================================
  // pins and tables
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic dirPin = 1'b0;
  logic stepAdvanceInput = 1'b0;
  wire chipSelectLow_n, serialClk, serialIn;
  logic serialOut, serialOutOe, stepModeReserved, compensatedHalf, rotateCcw, stepPulse;
  logic pwmDouble, pwmJitter, pwmTick, bridgeEnable, sleepMode, slaGainQuarter, slaTransparent;
  logic [2:0] stepModeSelect;
  logic [5:0] microstepsPerFull;
  logic [4:0] currentAmplitudeCode;
  logic [9:0] peakCoilCurrent;
  logic [1:0] slopeSelector;
  logic [7:0] slopeVoltsPerUs, r;
  logic [15:0] rx;
  int errors = 0, n_checks = 0, cyc = 0, pulses = 0, p, n;
  logic [4:0] curCode [5] = '{5'h00, 5'h03, 5'h0A, 5'h10, 5'h1F};
  logic [9:0] curMa [5] = '{10'h00F, 10'h032, 10'h064, 10'h0B5, 10'h320};
  logic [5:0] micro [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h00};
  logic [7:0] slope [4] = '{8'h96, 8'h64, 8'h32, 8'h19};
  logic [7:0] mask [3] = '{8'hFF, 8'hCF, 8'hF0};
  // open drain data line with pull-up
  wire doLine = serialOutOe ? 1'b0 : 1'b1;

  always #4 clk = ~clk;

  stp_ctrl_regs #(.PWM_CYCLES(40)) i_dut (.clk, .arst_n, .chipSelectLow_n, .serialClk,
    .serialIn, .serialOut, .serialOutOe, .dirPin, .stepAdvanceInput, .stepModeSelect,
    .stepModeReserved, .microstepsPerFull, .compensatedHalf, .currentAmplitudeCode,
    .peakCoilCurrent, .rotateCcw, .stepPulse, .pwmDouble, .pwmJitter, .pwmTick,
    .slopeSelector, .slopeVoltsPerUs, .bridgeEnable, .sleepMode, .slaGainQuarter,
    .slaTransparent);
  stp_spi_master i_spi (.clk, .chipSelectLow_n, .serialClk, .serialIn, .doLine);

  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_spi.frame({4'h4, a, d}, 16, rx);
    repeat (2) @(negedge clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    i_spi.frame({4'h0, a, 8'h00}, 16, rx);
    d = rx[7:0];
  endtask
  task automatic period(output int t);
    t = 0;
    for (int k = 0; k < 200 && pwmTick !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    while (pwmTick !== 1'b1 && t < 200) begin
      t++;
      @(negedge clk);
    end
    t++;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (stepPulse === 1'b1) pulses++;
    if (cyc == 40000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      final_report;
    end
  end

  // ==========================================================
  // tests
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    i_spi.hp = 6;
    for (int a = 1; a < 4; a++) begin
      rd(5'(a), r);
      chk(r, 8'h00);
    end
    i_spi.hp = 3;
    chk({microstepsPerFull, slopeVoltsPerUs, slaTransparent}, {6'h20, 8'h96, 1'b1});
    chk(peakCoilCurrent, 10'h00F);
    chk(serialOut, 1'b0);
    $display("test reset done");
    for (int a = 1; a < 4; a++) begin
      wr(5'(a), 8'hFF);
      rd(5'(a), r);
      chk(r, mask[a - 1]);
    end
    chk({pwmDouble, pwmJitter, slopeSelector}, 4'hF);
    chk({bridgeEnable, sleepMode, slaGainQuarter, slaTransparent}, 4'hE);
    i_spi.frame({2'h0, 8'h81, 7'h00}, 15, rx);
    i_spi.frame({8'h81, 8'h00, 1'b0}, 17, rx);
    wr(5'h04, 8'h00);
    rd(5'h01, r);
    chk(r, 8'hFF);
    p = pulses;
    stepAdvanceInput = 1'b1;
    repeat (4) @(negedge clk);
    stepAdvanceInput = 1'b0;
    period(n);
    chk(16'(pulses - p), 16'h0000);
    chk(16'(n), 16'h00C9);
    wr(5'h03, 8'h00);
    chk({bridgeEnable, sleepMode, slaGainQuarter, slaTransparent}, 4'h1);
    $display("test access done");
    for (int m = 0; m < 8; m++) begin
      wr(5'h01, {3'(m), 5'h1F});
      chk({stepModeSelect, stepModeReserved, compensatedHalf}, {3'(m), m == 7, m == 5});
      chk(microstepsPerFull, micro[m]);
    end
    for (int c = 0; c < 5; c++) begin
      wr(5'h01, {3'h0, curCode[c]});
      chk(currentAmplitudeCode, curCode[c]);
      chk(peakCoilCurrent, curMa[c]);
    end
    for (int s = 0; s < 4; s++) begin
      wr(5'h02, {6'h00, 2'(s)});
      chk(slopeVoltsPerUs, slope[s]);
    end
    for (int d = 0; d < 4; d++) begin
      dirPin = d[0];
      wr(5'h02, {d[1], 7'h00});
      chk(rotateCcw, d[0] ^ d[1]);
    end
    for (int pol = 0; pol < 2; pol++) begin
      wr(5'h02, {1'b0, pol[0], 6'h00});
      p = pulses;
      stepAdvanceInput = 1'b1;
      repeat (4) @(negedge clk);
      chk(16'(pulses - p), 16'(1 - pol));
      stepAdvanceInput = 1'b0;
      repeat (4) @(negedge clk);
      chk(16'(pulses - p), 16'h0001);
    end
    for (int f = 0; f < 3; f++) begin
      wr(5'h02, {4'h0, f == 1, f == 2, 2'h0});
      period(n);
      // six periods span more than the longest zero run of the lfsr
      p = 0;
      repeat (6) begin
        period(n);
        if (f < 2) chk(16'(n), f == 1 ? 16'h0014 : 16'h0028);
        else chk(16'(n >= 40 && n <= 55), 16'h0001);
        if (n != 40) p++;
      end
      if (f == 2) chk(16'(p > 0), 16'h0001);
    end
    $display("test decode done");
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    for (int a = 1; a < 4; a++) begin
      rd(5'(a), r);
      chk(r, 8'h00);
    end
    chk(peakCoilCurrent, 10'h00F);
    $display("test second reset done");
    final_report;
  end
endmodule

`default_nettype wire
